// >>> hdl/oss_pkg.sv
// Package of constants and types for the operation state sequencer.
//
// Notes on behaviour
// - Each button event taken in idle advances the state by exactly one; events during a pending conversion are dropped; otherwise state holds.
// - Eight states cycle; the eighth event returns to the reset state.
// - Order: low-volt, normal, low-use, normal, high-speed/error, normal, low-power, normal.
// - High-speed entry only when measured supply is at or above 2.4 V.
// - Supply below 2.4 V: stay low-speed normal, both LEDs blink fastest.
// - LED outputs and blink phase change only on the interval timer tick.
// - Each LED control status shows its own fixed or blinking LED pattern.
// - Clock source and frequency follow the current state.
// - LED control status is zero or one-hot: 00, 01, 02, 04, 08, 10 hex.
// - Reset configuration selects low-voltage mode, fast oscillator at 4 MHz.
// - Reset configuration leaves the watchdog stopped.
// - High-speed entry starts a conversion and waits for completion first.
// - Two LED output pins; the button comes from an interrupt-capable pin.
package oss_pkg;
  localparam int unsigned SYS_CLK_HZ       = 100_000_000;
  localparam int unsigned TICK_TIME_US     = 100;
  localparam int unsigned TICK_CYCLES      =
    TICK_TIME_US * (SYS_CLK_HZ / 1_000_000);
  localparam int unsigned TICK_CNT_W       = 17;
  // Supply threshold 2.4 V as a 10-bit code of a 3.6 V full scale.
  localparam logic [9:0]  SUPPLY_THRESH    = 10'h2AA;
  localparam logic [7:0]  CFG_BYTE_RESET   = 8'h2B;
  localparam logic [7:0]  WDT_BYTE_RESET   = 8'hEF;
  localparam logic [2:0]  STEP_LAST        = 3'h7;
  localparam logic [2:0]  STEP_HSPD        = 3'h4;
  localparam logic [7:0]  LEDST_LOWV       = 8'h00;
  localparam logic [7:0]  LEDST_NORM       = 8'h01;
  localparam logic [7:0]  LEDST_LOWUSE     = 8'h02;
  localparam logic [7:0]  LEDST_HSPD       = 8'h04;
  localparam logic [7:0]  LEDST_LPWR       = 8'h08;
  localparam logic [7:0]  LEDST_HSPD_ERR   = 8'h10;
  // Blink bit index in the tick phase counter; lower index blinks faster.
  localparam int unsigned BLINK_SLOW_BIT   = 5;
  localparam int unsigned BLINK_FAST_BIT   = 3;
  localparam int unsigned BLINK_FASTEST_BIT = 1;
  localparam int unsigned PHASE_W          = 6;

  typedef enum logic [2:0] {
    OSS_CLK_FAST_4M  = 3'h0,
    OSS_CLK_FAST_8M  = 3'h1,
    OSS_CLK_MID_4M   = 3'h2,
    OSS_CLK_FAST_16M = 3'h3,
    OSS_CLK_MID_1M   = 3'h4
  } oss_clk_type;

  typedef enum logic [3:0] {
    OSS_IDLE  = 4'b0001,
    OSS_START = 4'b0010,
    OSS_WAIT  = 4'b0100,
    OSS_DEC   = 4'b1000
  } oss_fsm_type;
endpackage

// >>> hdl/oss_led_driver.sv
// LED driver that refreshes the two LED pins on the interval tick.
`timescale 1ns/1ps
`default_nettype none
module oss_led_driver
  import oss_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic [7:0] led_status,
  output logic            led1_out_pin,
  output logic            led2_out_pin
);
  logic [PHASE_W-1:0] phase_r;
  logic [PHASE_W-1:0] phase_nxt;
  logic               led1_r;
  logic               led1_nxt;
  logic               led2_r;
  logic               led2_nxt;

  always_comb begin
    phase_nxt = phase_r;
    led1_nxt  = led1_r;
    led2_nxt  = led2_r;
    if (tick) begin
      phase_nxt = phase_r + 1'b1;
      unique case (led_status)
        LEDST_LOWV: begin
          led1_nxt = 1'b0;
          led2_nxt = 1'b1;
        end
        LEDST_NORM: begin
          led1_nxt = 1'b1;
          led2_nxt = 1'b0;
        end
        LEDST_LOWUSE: begin
          led1_nxt = phase_r[BLINK_FAST_BIT];
          led2_nxt = 1'b0;
        end
        LEDST_HSPD: begin
          led1_nxt = 1'b1;
          led2_nxt = 1'b1;
        end
        LEDST_LPWR: begin
          led1_nxt = phase_r[BLINK_SLOW_BIT];
          led2_nxt = 1'b0;
        end
        LEDST_HSPD_ERR: begin
          led1_nxt = phase_r[BLINK_FASTEST_BIT];
          led2_nxt = phase_r[BLINK_FASTEST_BIT];
        end
        default: begin
          led1_nxt = 1'b0;
          led2_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= '0;
      led1_r  <= 1'b0;
      led2_r  <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      led1_r  <= led1_nxt;
      led2_r  <= led2_nxt;
    end
  end

  assign led1_out_pin = led1_r;
  assign led2_out_pin = led2_r;

  a_led_tick_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(tick) |-> $stable(led1_out_pin) && $stable(led2_out_pin))
    else $error("LED changed without a tick");
  a_led_fast_both: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick && led_status == LEDST_HSPD |=> led1_out_pin && led2_out_pin)
    else $error("high-speed pattern wrong");
  a_led_lowv_pattern: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick && led_status == LEDST_LOWV |=> !led1_out_pin && led2_out_pin)
    else $error("low-voltage pattern wrong");
  a_led_err_equal: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick && led_status == LEDST_HSPD_ERR |=> led1_out_pin == led2_out_pin)
    else $error("error blink not in step");
endmodule
`default_nettype wire

// >>> hdl/oss_sequencer.sv
// Operation state sequencer stepping eight states on button events.
`timescale 1ns/1ps
`default_nettype none
module oss_sequencer
  import oss_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        button_in_pin,
  output logic             button_event_irq,
  output logic             adc_start,
  input  wire logic        adc_done,
  input  wire logic [9:0]  adc_result,
  output logic [2:0]       step_index,
  output logic [7:0]       led_status,
  output oss_clk_type      clk_select,
  output logic             high_speed_flash_mode,
  output logic             low_speed_flash_mode,
  output logic             low_voltage_flash_mode,
  output logic             low_power_flash_mode,
  output logic [7:0]       cfg_byte,
  output logic [7:0]       wdt_byte,
  output logic             watchdog_run,
  output logic             hspd_error,
  output logic             led1_out_pin,
  output logic             led2_out_pin
);
  logic                  sync1_r;
  logic                  sync2_r;
  logic                  prev_r;
  logic                  button_event_input;
  logic [TICK_CNT_W-1:0] tick_cnt_r;
  logic [TICK_CNT_W-1:0] tick_cnt_nxt;
  logic                  tick;
  oss_fsm_type           fsm_r;
  oss_fsm_type           fsm_nxt;
  logic [2:0]            step_r;
  logic [2:0]            step_nxt;
  logic                  err_r;
  logic                  err_nxt;
  logic [9:0]            res_r;
  logic [9:0]            res_nxt;

  // Button synchroniser and rising edge detector.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= button_in_pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end
  assign button_event_input = sync2_r & ~prev_r;
  assign button_event_irq   = button_event_input;

  // Periodic tick standing in for the 12-bit interval timer.
  always_comb begin
    tick         = (tick_cnt_r == TICK_CNT_W'(TICK_CYCLES - 1));
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // Events arriving while a conversion is pending are dropped.
  always_comb begin
    fsm_nxt  = fsm_r;
    step_nxt = step_r;
    err_nxt  = err_r;
    res_nxt  = res_r;
    unique case (fsm_r)
      OSS_IDLE: begin
        if (button_event_input) begin
          if (step_r + 3'h1 == STEP_HSPD) begin
            fsm_nxt = OSS_START;
          end else begin
            step_nxt = step_r + 3'h1;
            err_nxt  = 1'b0;
          end
        end
      end
      OSS_START: fsm_nxt = OSS_WAIT;
      OSS_WAIT: begin
        if (adc_done) begin
          res_nxt = adc_result;
          fsm_nxt = OSS_DEC;
        end
      end
      OSS_DEC: begin
        step_nxt = STEP_HSPD;
        err_nxt  = (res_r < SUPPLY_THRESH);
        fsm_nxt  = OSS_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fsm_r  <= OSS_IDLE;
      step_r <= 3'h0;
      err_r  <= 1'b0;
      res_r  <= '0;
    end else begin
      fsm_r  <= fsm_nxt;
      step_r <= step_nxt;
      err_r  <= err_nxt;
      res_r  <= res_nxt;
    end
  end

  assign adc_start  = (fsm_r == OSS_START);
  assign step_index = step_r;
  assign hspd_error = err_r;

  // Mode, clock and LED status decode from the step.
  always_comb begin
    unique case (step_r)
      3'h0: begin
        led_status = LEDST_LOWV;
        clk_select = OSS_CLK_FAST_4M;
      end
      3'h2: begin
        led_status = LEDST_LOWUSE;
        clk_select = OSS_CLK_MID_4M;
      end
      3'h4: begin
        led_status = err_r ? LEDST_HSPD_ERR : LEDST_HSPD;
        clk_select = err_r ? OSS_CLK_FAST_8M : OSS_CLK_FAST_16M;
      end
      3'h6: begin
        led_status = LEDST_LPWR;
        clk_select = OSS_CLK_MID_1M;
      end
      default: begin
        led_status = LEDST_NORM;
        clk_select = OSS_CLK_FAST_8M;
      end
    endcase
  end
  assign low_voltage_flash_mode = (led_status == LEDST_LOWV);
  assign high_speed_flash_mode  = (led_status == LEDST_HSPD);
  assign low_power_flash_mode   = (led_status == LEDST_LPWR);
  assign low_speed_flash_mode   = ~low_voltage_flash_mode &
                                  ~high_speed_flash_mode &
                                  ~low_power_flash_mode;
  assign cfg_byte     = CFG_BYTE_RESET;
  assign wdt_byte     = WDT_BYTE_RESET;
  assign watchdog_run = wdt_byte[4];

  oss_led_driver u_led (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .tick         (tick),
    .led_status   (led_status),
    .led1_out_pin (led1_out_pin),
    .led2_out_pin (led2_out_pin)
  );

  a_step_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !button_event_input && fsm_r == OSS_IDLE |=> $stable(step_r))
    else $error("step changed without event");
  a_step_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
    button_event_input && fsm_r == OSS_IDLE && step_r != 3'h3
    |=> step_r == $past(step_r) + 3'h1)
    else $error("step did not advance by one");
  a_wrap_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    button_event_input && fsm_r == OSS_IDLE && step_r == STEP_LAST
    |=> step_r == 3'h0 && led_status == LEDST_LOWV)
    else $error("no wrap to state 0");
  a_adc_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    adc_start |=> fsm_r == OSS_WAIT && step_r == 3'h3)
    else $error("left state 3 before conversion");
  a_supply_thresh: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fsm_r == OSS_DEC |=> step_r == STEP_HSPD &&
    hspd_error == ($past(res_r) < SUPPLY_THRESH))
    else $error("threshold decision wrong");
  a_err_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hspd_error && step_r == STEP_HSPD |-> clk_select == OSS_CLK_FAST_8M &&
    led_status == LEDST_HSPD_ERR)
    else $error("error state not low-speed");
  a_press_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
    button_event_input |=> !button_event_input)
    else $error("double event on one press");
  a_lowpwr_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step_r == 3'h6 |-> clk_select == OSS_CLK_MID_1M)
    else $error("low-power clock wrong");

  c_fast_enter: cover property (@(posedge sys_clk) disable iff (!rst_n)
    fsm_r == OSS_DEC ##1 !hspd_error);
  c_fast_error: cover property (@(posedge sys_clk) disable iff (!rst_n)
    fsm_r == OSS_DEC ##1 hspd_error);
  c_wrap: cover property (@(posedge sys_clk) disable iff (!rst_n)
    step_r == STEP_LAST ##1 step_r == 3'h0);
endmodule
`default_nettype wire

// >>> testbench/oss_supply_model.sv
// Supply converter model that answers conversion requests after a delay.
`timescale 1ns/1ps
`default_nettype none
module oss_supply_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       adc_start,
  input  wire logic [9:0] supply_code,
  input  wire logic [7:0] latency,
  output logic            adc_done,
  output logic [9:0]      adc_result
);
  logic [8:0] cnt_r;

  // Outside the completion cycle the result bus toggles so stale data shows.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 9'h000;
      adc_done <= 1'b0;
      adc_result <= 10'h000;
    end else begin
      adc_done <= (cnt_r == 9'h001);
      adc_result <= (cnt_r == 9'h001) ? supply_code : ~adc_result;
      if (adc_start)
        cnt_r <= {1'b0, latency};
      else if (cnt_r != 9'h000)
        cnt_r <= cnt_r - 9'h001;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/test_operation_state_sequencer.sv
// Self-checking bench stepping the sequencer through its states.
`timescale 1ns/1ps
`default_nettype none
module test_operation_state_sequencer;
  import oss_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        button_in_pin = 1'b0;
  logic [9:0]  supply_code = 10'h2AA;
  logic [7:0]  latency = 8'h08;
  logic        adc_start, adc_done, button_event_irq, watchdog_run, hspd_error;
  logic [9:0]  adc_result;
  logic [2:0]  step_index;
  logic [7:0]  led_status, cfg_byte, wdt_byte;
  oss_clk_type clk_select;
  logic        led1_out_pin, led2_out_pin;
  logic        high_speed_flash_mode, low_speed_flash_mode;
  logic        low_voltage_flash_mode, low_power_flash_mode;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [7:0]  led_exp [8] = '{8'h00, 8'h01, 8'h02, 8'h01,
                               8'h04, 8'h01, 8'h08, 8'h01};
  logic [2:0]  clk_exp [8] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h3, 3'h1, 3'h4, 3'h1};
  logic [3:0]  mode_exp [8] = '{4'h8, 4'h4, 4'h4, 4'h4, 4'h2, 4'h4, 4'h1, 4'h4};

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (rst_n)
      cyc++;
  end

  oss_sequencer oss_sequencer_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .button_in_pin(button_in_pin),
    .button_event_irq(button_event_irq), .adc_start(adc_start),
    .adc_done(adc_done), .adc_result(adc_result),
    .step_index(step_index), .led_status(led_status),
    .clk_select(clk_select),
    .high_speed_flash_mode(high_speed_flash_mode),
    .low_speed_flash_mode(low_speed_flash_mode),
    .low_voltage_flash_mode(low_voltage_flash_mode),
    .low_power_flash_mode(low_power_flash_mode), .cfg_byte(cfg_byte),
    .wdt_byte(wdt_byte), .watchdog_run(watchdog_run), .hspd_error(hspd_error),
    .led1_out_pin(led1_out_pin), .led2_out_pin(led2_out_pin));

  oss_supply_model oss_supply_model_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .adc_start(adc_start),
    .supply_code(supply_code), .latency(latency), .adc_done(adc_done),
    .adc_result(adc_result));

  task automatic give_verdict;
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the button high for the given number of cycles, then settles.
  task automatic press(input int hold);
    @(posedge sys_clk) button_in_pin <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    button_in_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic check_state(input int k, input logic err);
    cmp(step_index, k[2:0]);
    cmp(led_status, err ? 8'h10 : led_exp[k]);
    cmp(clk_select, err ? 3'h1 : clk_exp[k]);
    cmp({low_voltage_flash_mode, low_speed_flash_mode, high_speed_flash_mode,
         low_power_flash_mode}, err ? 4'h4 : mode_exp[k]);
    cmp(hspd_error, err);
    cmp(button_event_irq, 1'b0);
    cmp(adc_start, 1'b0);
  endtask

  // Runs presses from step first to step last, wrapping after step 7.
  task automatic run_steps(input int first, input int last);
    for (int k = first; k <= last; k++) begin
      press(20);
      check_state(k % 8, (k == 4) && (supply_code < SUPPLY_THRESH));
    end
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    check_state(0, 1'b0);
    cmp(cfg_byte, 8'h2B);
    cmp(wdt_byte, 8'hEF);
    cmp(watchdog_run, 1'b0);
    cmp({led1_out_pin, led2_out_pin}, 2'b00);
    repeat (50) @(posedge sys_clk);
    #1;
    check_state(0, 1'b0);
    run_steps(1, 8);
    @(posedge sys_clk);
    supply_code <= 10'h2A9;
    run_steps(1, 8);
    @(posedge sys_clk);
    latency <= 8'h28;
    run_steps(1, 3);
    press(2);
    cmp(step_index, 3'h3);
    press(2);
    repeat (40) @(posedge sys_clk);
    #1;
    check_state(4, 1'b1);
    run_steps(5, 8);
    cmp({led1_out_pin, led2_out_pin}, 2'b00);
    while (led2_out_pin !== 1'b1 && cyc < 15000)
      @(posedge sys_clk);
    #1;
    cmp(cyc >= TICK_CYCLES - 2, 1'b1);
    cmp({led1_out_pin, led2_out_pin}, 2'b01);
    give_verdict;
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    give_verdict;
  end
endmodule
`default_nettype wire
